// ### code_flasher.sv
// counted flash sequencer for multi-digit decimal fault codes
`timescale 1ns/1ps
module code_flasher
    import relay_pkg::*;
#(
    parameter int unsigned SHORT_ON   = SHORT_ON_CYC,
    parameter int unsigned SHORT_OFF  = SHORT_OFF_CYC,
    parameter int unsigned OPEN_PAUSE = OPEN_PAUSE_CYC,
    parameter int unsigned DIGIT_ON   = DIGIT_ON_CYC,
    parameter int unsigned DIGIT_OFF  = DIGIT_OFF_CYC,
    parameter int unsigned DIGIT_GAP  = DIGIT_GAP_CYC,
    parameter int unsigned REST       = REST_CYC
) (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   enable,
    input  wire code_t  code,
    output logic        led
);

    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_OPEN_ON   = 10'h002,
        ST_OPEN_OFF  = 10'h004,
        ST_PAUSE     = 10'h008,
        ST_DIG_ON    = 10'h010,
        ST_DIG_OFF   = 10'h020,
        ST_GAP       = 10'h040,
        ST_CLOSE_ON  = 10'h080,
        ST_CLOSE_OFF = 10'h100,
        ST_REST      = 10'h200
    } fl_state_t;

    // zero is shown as sixteen flashes
    function automatic logic [4:0] flashes_of(input logic [3:0] d);
        return (d == 4'h0) ? ZERO_FLASHES : {1'b0, d};
    endfunction

    fl_state_t    state_q, state_d;
    logic [31:0]  timer_q;
    logic [31:0]  limit;
    logic [4:0]   flash_q;
    logic [1:0]   digit_q;
    logic [1:0]   short_q;
    logic         expire;
    logic [4:0]   target;
    logic         last_flash;
    logic         last_digit;
    logic         last_short;

    assign limit = (state_q == ST_OPEN_ON || state_q == ST_CLOSE_ON)
                 ? SHORT_ON
                 : (state_q == ST_OPEN_OFF || state_q == ST_CLOSE_OFF)
                 ? SHORT_OFF
                 : (state_q == ST_PAUSE)   ? OPEN_PAUSE
                 : (state_q == ST_DIG_ON)  ? DIGIT_ON
                 : (state_q == ST_DIG_OFF) ? DIGIT_OFF
                 : (state_q == ST_GAP)     ? DIGIT_GAP
                 : REST;
    assign expire     = (timer_q == limit - 32'h1);
    assign target     = flashes_of(code.digit[digit_q]);
    assign last_flash = (flash_q == target - 5'h1);
    assign last_digit = ({1'b0, digit_q} == code.ndig - 3'h1)
                      || (digit_q == 2'(MAX_DIGITS - 1));
    assign last_short = (short_q == 2'(SHORT_FLASHES - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:      state_d = ST_OPEN_ON;
            ST_OPEN_ON:   if (expire) state_d = ST_OPEN_OFF;
            ST_OPEN_OFF:  if (expire) state_d = last_short ? ST_PAUSE
                                                           : ST_OPEN_ON;
            ST_PAUSE:     if (expire) state_d = ST_DIG_ON;
            ST_DIG_ON:    if (expire) state_d = ST_DIG_OFF;
            ST_DIG_OFF: begin
                if (expire) begin
                    if (!last_flash)
                        state_d = ST_DIG_ON;
                    else if (!last_digit)
                        state_d = ST_GAP;
                    else
                        state_d = ST_CLOSE_ON;
                end
            end
            ST_GAP:       if (expire) state_d = ST_DIG_ON;
            ST_CLOSE_ON:  if (expire) state_d = ST_CLOSE_OFF;
            ST_CLOSE_OFF: if (expire) state_d = last_short ? ST_REST
                                                           : ST_CLOSE_ON;
            ST_REST:      if (expire) state_d = ST_OPEN_ON;
            default:      state_d = ST_IDLE;
        endcase
        if (!enable || code.ndig == 3'h0)
            state_d = ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h0;
            flash_q <= 5'h0;
            digit_q <= 2'h0;
            short_q <= 2'h0;
            led     <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= (state_d != state_q) ? 32'h0 : timer_q + 32'h1;
            if (expire && (state_q == ST_OPEN_OFF
                           || state_q == ST_CLOSE_OFF))
                short_q <= last_short ? 2'h0 : short_q + 2'h1;
            if (state_q == ST_PAUSE)
                digit_q <= 2'h0;
            if (expire && state_q == ST_DIG_OFF) begin
                flash_q <= last_flash ? 5'h0 : flash_q + 5'h1;
                if (last_flash && !last_digit)
                    digit_q <= digit_q + 2'h1;
            end
            led <= (state_d == ST_OPEN_ON) || (state_d == ST_DIG_ON)
                || (state_d == ST_CLOSE_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !enable);

    sequence s_open_done;
        state_q == ST_OPEN_OFF && expire && last_short;
    endsequence

    sequence s_digit_more;
        state_q == ST_DIG_OFF && expire && !last_flash;
    endsequence

    chk_open_three_short: assert property (
        s_open_done |=> state_q == ST_PAUSE && !led)
        else $error("opening shorts not followed by pause");

    chk_zero_sixteen: assert property (
        state_q == ST_DIG_OFF && expire && code.digit[digit_q] == 4'h0
        && flash_q < 5'h0f |=> state_q == ST_DIG_ON)
        else $error("zero digit not sixteen flashes");

    chk_digit_count: assert property (
        s_digit_more |=> state_q == ST_DIG_ON ##0 led)
        else $error("digit flash count cut short");

    chk_close_repeat: assert property (
        state_q == ST_CLOSE_OFF && expire && last_short
        |=> state_q == ST_REST ##0 short_q == 2'h0)
        else $error("sequence does not rest and repeat");

endmodule

// ### linked_unit.sv
// behavioural upstream relay unit driving the logic inputs
`timescale 1ns/1ps
module linked_unit (
    input  wire logic clk,
    input  wire logic want_and,
    input  wire logic want_or,
    output logic      and_level,
    output logic      or_level
);
    initial begin
        and_level = 1'b1;
        or_level  = 1'b0;
    end
    // outputs switch on the clock; and is raised before any press
    always @(posedge clk) begin
        and_level <= want_and;
        or_level  <= want_or;
    end
endmodule

// ### relay_logic.sv
// two-hand relay output logic, supply watchdog and indicator sequencing
`timescale 1ns/1ps
module relay_logic
    import relay_pkg::*;
#(
    parameter int unsigned SUPPLY_LOSS  = SUPPLY_LOSS_CYC,
    parameter int unsigned RESTART_OFF  = RESTART_CYC,
    parameter int unsigned INIT_TIME    = INIT_CYC,
    parameter int unsigned POWER_BLINK  = POWER_BLINK_CYC,
    parameter int unsigned BRIEF_ON     = BRIEF_ON_CYC,
    parameter int unsigned BRIEF_OFF    = BRIEF_OFF_CYC,
    parameter int unsigned ALT_TIME     = ALT_CYC,
    parameter int unsigned TEST_PERIOD  = TEST_PERIOD_CYC,
    parameter int unsigned TEST_WIDTH   = TEST_WIDTH_CYC,
    parameter int unsigned SHORT_ON     = SHORT_ON_CYC,
    parameter int unsigned SHORT_OFF    = SHORT_OFF_CYC,
    parameter int unsigned OPEN_PAUSE   = OPEN_PAUSE_CYC,
    parameter int unsigned DIGIT_ON     = DIGIT_ON_CYC,
    parameter int unsigned DIGIT_OFF    = DIGIT_OFF_CYC,
    parameter int unsigned DIGIT_GAP    = DIGIT_GAP_CYC,
    parameter int unsigned REST         = REST_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       supply_ok,
    input  wire logic       or_logic_input,
    input  wire logic       and_logic_input,
    input  wire logic       button_one,
    input  wire logic       button_two,
    input  wire logic [1:0] mode_select,
    input  wire fault_in_t  faults,
    input  wire code_t      fault_code,
    output logic            safety_out_one,
    output logic            safety_out_two,
    output logic            power_indicator,
    output logic            channel_one_indicator,
    output logic            channel_two_indicator,
    output logic [1:0]      detected_mode,
    output logic            fault_latched
);

    typedef enum logic [2:0] {
        ST_INIT  = 3'h1,
        ST_READY = 3'h2,
        ST_FAULT = 3'h4
    } top_state_t;

    // free-running wrap counter step
    function automatic logic [31:0] wrap_next(input logic [31:0] cnt,
                                               input logic [31:0] lim);
        return (cnt >= lim - 32'h1) ? 32'h0 : cnt + 32'h1;
    endfunction

    top_state_t   state_q, state_d;
    logic [31:0]  init_cnt_q;
    logic [31:0]  off_cnt_q;
    logic         rearm_q;
    logic         armed_q, armed_d;
    logic         run_q, run_d;
    logic         start_seen_q;
    logic         and_prev_q;
    logic [31:0]  tp_cnt_q;
    logic [31:0]  brief_cnt_q;
    logic [31:0]  alt_cnt_q;
    logic         alt_phase_q;
    logic [31:0]  pwr_cnt_q;
    logic         pwr_phase_q;

    ////////////////////////////////////////////////////////////////////////
    // supply watchdog and top sequencing

    logic  ready;
    logic  both_pressed;
    logic  both_released;
    logic  loss_hit;
    logic  restart;
    logic  any_fault;

    assign ready         = (state_q == ST_READY);
    assign both_pressed  = button_one && button_two;
    assign both_released = !button_one && !button_two;
    assign loss_hit      = !supply_ok
                        && (off_cnt_q >= SUPPLY_LOSS - 32'h1);
    assign restart       = supply_ok && rearm_q;
    assign any_fault     = faults.coded || faults.simult || faults.button
                        || faults.alternate;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT:  if (init_cnt_q >= INIT_TIME - 32'h1)
                          state_d = ST_READY;
            ST_READY: if (loss_hit) state_d = ST_FAULT;
            ST_FAULT: if (restart) state_d = ST_INIT;
            default:  state_d = ST_FAULT;
        endcase
        if (state_q != ST_FAULT && loss_hit)
            state_d = ST_FAULT;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= ST_INIT;
            init_cnt_q <= 32'h0;
            off_cnt_q  <= 32'h0;
            rearm_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            init_cnt_q <= (state_q == ST_INIT) ? init_cnt_q + 32'h1 : 32'h0;
            off_cnt_q  <= supply_ok ? 32'h0
                        : (off_cnt_q == 32'hffffffff) ? off_cnt_q
                        : off_cnt_q + 32'h1;
            if (state_q != ST_FAULT)
                rearm_q <= 1'b0;
            else if (!supply_ok && off_cnt_q >= RESTART_OFF - 32'h1)
                rearm_q <= 1'b1;
        end
    end

    // operating mode caught at end of init
    always_ff @(posedge clk) begin
        if (rst)
            detected_mode <= MODE_INVALID;
        else if (state_q == ST_INIT && state_d == ST_READY)
            detected_mode <= mode_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // two-hand enable with AND/OR logic inputs

    // run decided first; arming reads this cycle's run decision
    always_comb begin
        run_d = run_q;
        if (!ready || any_fault || !both_pressed || !and_logic_input)
            run_d = 1'b0;
        else if (armed_q)
            run_d = 1'b1;
        armed_d = armed_q;
        if (!and_logic_input)
            armed_d = 1'b0;
        else if (both_released)
            armed_d = 1'b1;
        else if (run_d)
            armed_d = 1'b0;
    end

    logic  logic_hi;
    logic  pulse_one;
    logic  pulse_two;
    logic  half_period;

    assign logic_hi = ready && supply_ok && !faults.coded
                   && (or_logic_input
                       || (and_logic_input && run_q));
    assign half_period = (tp_cnt_q >= TEST_PERIOD / 2);
    assign pulse_one   = (tp_cnt_q < TEST_WIDTH);
    assign pulse_two   = half_period
                      && (tp_cnt_q < TEST_PERIOD / 2 + TEST_WIDTH);

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_q        <= 1'b0;
            run_q          <= 1'b0;
            start_seen_q   <= 1'b0;
            and_prev_q     <= 1'b1;
            tp_cnt_q       <= 32'h0;
            safety_out_one <= 1'b0;
            safety_out_two <= 1'b0;
            fault_latched  <= 1'b0;
        end else begin
            armed_q        <= armed_d;
            run_q          <= run_d;
            start_seen_q   <= ready && (start_seen_q || run_q);
            and_prev_q     <= and_logic_input;
            tp_cnt_q       <= wrap_next(tp_cnt_q, TEST_PERIOD);
            safety_out_one <= logic_hi && !pulse_one;
            safety_out_two <= logic_hi && !pulse_two;
            fault_latched  <= (state_d == ST_FAULT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators

    logic   flash_led;
    logic   show_code;
    logic   brief_on;
    logic   power_steady;
    logic   ch_one_d;
    logic   ch_two_d;
    code_t  shown_code;

    assign show_code    = (state_q == ST_FAULT) || faults.coded;
    assign shown_code   = (state_q == ST_FAULT) ? SUPPLY_CODE : fault_code;
    assign brief_on     = (brief_cnt_q < BRIEF_ON);
    assign power_steady = ready && detected_mode != MODE_INVALID
                       && start_seen_q;
    assign ch_one_d = show_code        ? flash_led
                    : faults.button    ? brief_on
                    : faults.simult    ? brief_on
                    : faults.alternate ? alt_phase_q
                    : logic_hi;
    assign ch_two_d = show_code        ? 1'b0
                    : faults.button    ? brief_on
                    : faults.simult    ? 1'b0
                    : faults.alternate ? !alt_phase_q
                    : logic_hi;

    code_flasher #(
        .SHORT_ON   (SHORT_ON),
        .SHORT_OFF  (SHORT_OFF),
        .OPEN_PAUSE (OPEN_PAUSE),
        .DIGIT_ON   (DIGIT_ON),
        .DIGIT_OFF  (DIGIT_OFF),
        .DIGIT_GAP  (DIGIT_GAP),
        .REST       (REST)
    ) u_flasher (
        .clk    (clk),
        .rst    (rst),
        .enable (show_code),
        .code   (shown_code),
        .led    (flash_led)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            brief_cnt_q           <= 32'h0;
            alt_cnt_q             <= 32'h0;
            alt_phase_q           <= 1'b0;
            pwr_cnt_q             <= 32'h0;
            pwr_phase_q           <= 1'b0;
            power_indicator       <= 1'b0;
            channel_one_indicator <= 1'b0;
            channel_two_indicator <= 1'b0;
        end else begin
            brief_cnt_q <= wrap_next(brief_cnt_q, BRIEF_ON + BRIEF_OFF);
            alt_cnt_q   <= wrap_next(alt_cnt_q, ALT_TIME);
            if (alt_cnt_q >= ALT_TIME - 32'h1)
                alt_phase_q <= !alt_phase_q;
            pwr_cnt_q   <= wrap_next(pwr_cnt_q, POWER_BLINK);
            if (pwr_cnt_q >= POWER_BLINK - 32'h1)
                pwr_phase_q <= !pwr_phase_q;
            power_indicator <= (state_q == ST_FAULT) ? 1'b0
                             : power_steady ? 1'b1
                             : pwr_phase_q;
            channel_one_indicator <= ch_one_d;
            channel_two_indicator <= ch_two_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_and_low_off: assert property (
        !and_logic_input && !or_logic_input
        |=> !safety_out_one && !safety_out_two)
        else $error("outputs high with AND input low");

    chk_or_forces_high: assert property (
        or_logic_input && ready && supply_ok && !faults.coded && !pulse_one
        |=> safety_out_one)
        else $error("OR input did not force output high");

    chk_late_and_blocked: assert property (
        !and_prev_q && and_logic_input && both_pressed
        |=> !run_q [*2])
        else $error("enabled without re-press after AND rise");

    chk_or_low_path: assert property (
        !or_logic_input && !run_q |=> !safety_out_one && !safety_out_two)
        else $error("output high without own enable");

    chk_test_pulse: assert property (
        pulse_one |=> !safety_out_one)
        else $error("test pulse missing on first output");

    chk_supply_fault: assert property (
        loss_hit |=> fault_latched ##1 !safety_out_one && !safety_out_two)
        else $error("supply loss not latched or outputs high");

    chk_fault_holds: assert property (
        state_q == ST_FAULT && !rearm_q |=> state_q == ST_FAULT)
        else $error("fault left without power-off time");

    chk_power_steady: assert property (
        power_steady |=> power_indicator)
        else $error("power indicator not steady when ready");

    chk_channel_follow: assert property (
        !show_code && !any_fault |=> channel_one_indicator == safety_out_one
                                  || $past(pulse_one))
        else $error("channel indicator does not follow output");

endmodule

// ### relay_pkg.sv
// shared constants and carrier types for the two-hand relay logic
package relay_pkg;

    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned CYC_PER_US      = CLK_MHZ;
    localparam int unsigned CYC_PER_MS      = CLK_MHZ * 1000;

    // times in their own units
    localparam int unsigned SUPPLY_LOSS_MS  = 20;
    localparam int unsigned RESTART_OFF_MS  = 1000;
    localparam int unsigned BRIEF_ON_MS     = 50;
    localparam int unsigned BRIEF_OFF_MS    = 250;
    localparam int unsigned DIGIT_ON_MS     = 1000;
    localparam int unsigned DIGIT_OFF_MS    = 1000;
    localparam int unsigned SHORT_ON_MS     = 150;
    localparam int unsigned SHORT_OFF_MS    = 150;
    localparam int unsigned OPEN_PAUSE_MS   = 3000;
    localparam int unsigned DIGIT_GAP_MS    = 3000;
    localparam int unsigned REST_MS         = 4000;
    localparam int unsigned INIT_MS         = 200;
    localparam int unsigned POWER_BLINK_MS  = 250;
    localparam int unsigned ALT_MS          = 500;
    localparam int unsigned TEST_PERIOD_MS  = 10;
    localparam int unsigned TEST_WIDTH_US   = 500;

    // derived cycle counts
    localparam int unsigned SUPPLY_LOSS_CYC = SUPPLY_LOSS_MS * CYC_PER_MS;
    localparam int unsigned RESTART_CYC     = RESTART_OFF_MS * CYC_PER_MS;
    localparam int unsigned BRIEF_ON_CYC    = BRIEF_ON_MS * CYC_PER_MS;
    localparam int unsigned BRIEF_OFF_CYC   = BRIEF_OFF_MS * CYC_PER_MS;
    localparam int unsigned DIGIT_ON_CYC    = DIGIT_ON_MS * CYC_PER_MS;
    localparam int unsigned DIGIT_OFF_CYC   = DIGIT_OFF_MS * CYC_PER_MS;
    localparam int unsigned SHORT_ON_CYC    = SHORT_ON_MS * CYC_PER_MS;
    localparam int unsigned SHORT_OFF_CYC   = SHORT_OFF_MS * CYC_PER_MS;
    localparam int unsigned OPEN_PAUSE_CYC  = OPEN_PAUSE_MS * CYC_PER_MS;
    localparam int unsigned DIGIT_GAP_CYC   = DIGIT_GAP_MS * CYC_PER_MS;
    localparam int unsigned REST_CYC        = REST_MS * CYC_PER_MS;
    localparam int unsigned INIT_CYC        = INIT_MS * CYC_PER_MS;
    localparam int unsigned POWER_BLINK_CYC = POWER_BLINK_MS * CYC_PER_MS;
    localparam int unsigned ALT_CYC         = ALT_MS * CYC_PER_MS;
    localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_MS * CYC_PER_MS;
    localparam int unsigned TEST_WIDTH_CYC  = TEST_WIDTH_US * CYC_PER_US;

    localparam int unsigned SHORT_FLASHES   = 3;
    localparam int unsigned MAX_DIGITS      = 4;
    localparam logic [4:0]  ZERO_FLASHES    = 5'h10;
    localparam logic [1:0]  MODE_INVALID    = 2'h3;

    typedef struct packed {
        logic [2:0]       ndig;
        logic [3:0][3:0]  digit;
    } code_t;

    typedef struct packed {
        logic  coded;
        logic  simult;
        logic  button;
        logic  alternate;
    } fault_in_t;

    // supply interruption code 8,2
    localparam code_t SUPPLY_CODE = '{ndig: 3'h2,
                                      digit: {4'h0, 4'h0, 4'h2, 4'h8}};

endpackage

// ### testbench.sv
// self-checking bench for the two-hand relay logic
`timescale 1ns/1ps
module testbench;
    import relay_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, supply_ok = 1'b1;
    logic       want_and = 1'b1, want_or = 1'b0;
    logic       button_one = 1'b0, button_two = 1'b0;
    logic [1:0] mode_select = 2'h0, dmode;
    fault_in_t  faults = '0;
    code_t      fault_code = '0, c;
    logic       and_level, or_level, s1, s2, pwr, ch1, ch2, fl;
    int         n_fail = 0, samples_checked = 0, cycles = 0, a, b, e;
    localparam int unsigned LOSS = 20, OFF_T = 100, INIT_T = 10, BLINK = 4;
    localparam int unsigned BON = 2, BOFF = 10, ALT = 5, TPER = 40, TW = 2;
    localparam int unsigned SON = 2, SOFF = 2, PAUSE = 8, DON = 4, DOFF = 4;
    localparam int unsigned GAP = 8, RST_T = 10;
    always #2 clk = ~clk;
    linked_unit i_up (.clk(clk), .want_and(want_and), .want_or(want_or),
        .and_level(and_level), .or_level(or_level));
    relay_logic #(.SUPPLY_LOSS(LOSS), .RESTART_OFF(OFF_T), .INIT_TIME(INIT_T),
        .POWER_BLINK(BLINK), .BRIEF_ON(BON), .BRIEF_OFF(BOFF), .ALT_TIME(ALT),
        .TEST_PERIOD(TPER), .TEST_WIDTH(TW), .SHORT_ON(SON), .SHORT_OFF(SOFF),
        .OPEN_PAUSE(PAUSE), .DIGIT_ON(DON), .DIGIT_OFF(DOFF), .DIGIT_GAP(GAP),
        .REST(RST_T)) i_dut (.clk(clk), .rst(rst), .supply_ok(supply_ok),
        .or_logic_input(or_level), .and_logic_input(and_level),
        .button_one(button_one), .button_two(button_two),
        .mode_select(mode_select), .faults(faults), .fault_code(fault_code),
        .safety_out_one(s1), .safety_out_two(s2), .power_indicator(pwr),
        .channel_one_indicator(ch1), .channel_two_indicator(ch2),
        .detected_mode(dmode), .fault_latched(fl));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic press(input logic v);
        @(posedge clk);
        button_one <= v;
        button_two <= v;
    endtask
    // counts high cycles of both channels and cycles where they agree
    task automatic tally(input int n);
        a = 0; b = 0; e = 0;
        repeat (n) begin
            @(negedge clk);
            a += ch1; b += ch2; e += (ch1 == ch2);
        end
    endtask
    function automatic logic [31:0] nflash(input logic [3:0] d);
        return (d == 4'h0) ? 32'h10 : {28'h0, d};
    endfunction
    // groups long flashes between the opening and closing short triples
    task automatic watch_code(input code_t k);
        int w, d, cnt, g, sh;
        @(negedge clk);
        for (int r = 0; r < 2; r++) begin
            g = 0; sh = 0; cnt = 0;
            while (sh < 6) begin
                d = 0; w = 0;
                while (ch1 !== 1'b1 && d < 200) begin @(negedge clk); d++; end
                while (ch1 === 1'b1 && w < 200) begin @(negedge clk); w++; end
                if (cnt > 0 && (d > 4 || w <= 2)) begin
                    check(cnt, nflash(k.digit[g[1:0]]));
                    g++; cnt = 0;
                end
                if (w <= 2) sh++;
                else cnt++;
            end
            check(g, k.ndig);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        a = $urandom(32'he7fbb11b);
        mode_select <= 2'($urandom_range(2, 0));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_cyc(2);
        check(s1 | s2, 1'b0);
        a = 0;
        repeat (16) begin @(negedge clk); a += pwr; end
        check(a > 0 && a < 16, 1'b1);
        check(dmode, mode_select);
        press(1'b1);
        wait_cyc(3);
        check({ch1, ch2}, 2'h3);
        a = 0; b = 0;
        repeat (TPER) begin @(negedge clk); a += !s1; b += !s2; end
        check(a, TW);
        check(b, TW);
        tally(16);
        check(a, 16);
        check(b, 16);
        a = 0;
        repeat (16) begin @(negedge clk); a += pwr; end
        check(a, 16);
        @(posedge clk) want_and <= 1'b0;
        wait_cyc(4);
        check({ch1, ch2, s1, s2}, 4'h0);
        @(posedge clk) want_and <= 1'b1;
        wait_cyc(3 + $urandom_range(8));
        check({ch1, ch2}, 2'h0);
        press(1'b0);
        wait_cyc(2);
        press(1'b1);
        wait_cyc(4);
        check({ch1, ch2}, 2'h3);
        press(1'b0);
        wait_cyc(4);
        check({ch1, ch2}, 2'h0);
        @(posedge clk) want_or <= 1'b1;
        wait_cyc(4);
        check({ch1, ch2}, 2'h3);
        @(posedge clk) want_or <= 1'b0;
        wait_cyc(4);
        check({ch1, ch2}, 2'h0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) faults <= fault_in_t'(4'h4 >> k);
            wait_cyc(24);
            tally(5 * (BON + BOFF));
            if (k < 2) begin
                check(a, 5 * BON);
                check(b, k ? 5 * BON : 0);
            end else
                check(e, 0);
        end
        for (int r = 0; r < 3; r++) begin
            @(posedge clk) faults <= '0;
            wait_cyc(20);
            c.ndig = 3'($urandom_range(4, 1));
            c.digit = 16'($urandom);
            if (r == 0) c.digit[0] = 4'h0;
            @(posedge clk) begin
                fault_code <= c;
                faults <= fault_in_t'(4'h8);
            end
            watch_code(c);
        end
        @(posedge clk) faults <= '0;
        wait_cyc(20);
        @(posedge clk) supply_ok <= 1'b0;
        wait_cyc(LOSS + 4);
        check({fl, s1, s2, pwr, ch2}, 5'h10);
        @(posedge clk) supply_ok <= 1'b1;
        watch_code(SUPPLY_CODE);
        check(fl, 1'b1);
        @(posedge clk) supply_ok <= 1'b0;
        wait_cyc(OFF_T + 10);
        @(posedge clk) supply_ok <= 1'b1;
        wait_cyc(4);
        check(fl, 1'b0);
        @(posedge clk) begin
            rst <= 1'b1;
            mode_select <= MODE_INVALID;
        end
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_cyc(2);
        check({fl, s1, s2, dmode}, 5'h03);
        wait_cyc(INIT_T + 4);
        press(1'b1);
        wait_cyc(4);
        a = 0;
        repeat (16) begin @(negedge clk); a += pwr; end
        check({a > 0 && a < 16, dmode}, 3'h7);
        report_and_stop();
    end
endmodule
